// *** hdl/wdr_watchdog_reset.sv ***
// reset sequencer, reset cause capture and software watchdog
//
// Function
// - any reset puts the clock generator into self-clocked reset mode
// - drive reset pin low 34 bus cycles, bus at half clock, then release
// - 38 bus cycles after release sample pin to detect external pin reset
// - seven reset sources: por, low voltage, watchdog, opcode, debug, pin, clock
// - each source but debug has a cause bit showing the latest reset
// - external pin reset can be disabled by reset_pin_enable in options two
// - pc loaded from vector 0xfffe/0xffff, stack pointer forced to 0x00ff
// - reset sets the interrupt mask bit in condition codes
// - reset disables peripherals, pins become hi-z inputs without pullups
// - watchdog enable set after any reset; clearing it stops the watchdog
// - watchdog timeout without service causes a system reset
// - any write to cause register address clears watchdog, contents unchanged
// - clock select picks bus clock or about 1 khz tick for the watchdog
// - overflow 2^5, 2^8 (1 khz) or 2^13, 2^18 (bus) by select bits
// - default after reset is 1 khz source with long 2^8 timeout
// - both option registers take one write after reset, then lock
// - first writes to the option registers also clear the watchdog
// - bus clock mode holds the counter in debug or stop, resumes after
// - 1 khz mode clears the counter in debug or stop, counts from zero
`timescale 1ns/100ps

module wdr_watchdog_reset
  import wdr_pkg::*;
#(
  parameter int unsigned KHZ_DIV = KHZ_DIV_CYC
)(
  // clock and power-on reset
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // other reset sources, same clock domain
  input  wire logic        lvd_reset_i,
  input  wire logic        illegal_opcode_i,
  input  wire logic        debug_reset_i,
  input  wire logic        clock_loss_i,
  // external reset pin, open drain
  input  wire logic        reset_pin_i,
  output logic             reset_pin_o,
  output logic             reset_pin_oe_o,
  // cpu mode
  input  wire logic        debug_mode_i,
  input  wire logic        stop_mode_i,
  // software register writes
  input  wire logic        cause_wr_i,
  input  wire logic        opt1_wr_i,
  input  wire logic        opt2_wr_i,
  input  wire logic [7:0]  wr_data_i,
  // register read back
  output wdr_cause_s       reset_cause_o,
  output wdr_opt1_s        opt1_o,
  output wdr_opt2_s        opt2_o,
  // reset vector fetch
  output logic             vec_rd_o,
  output logic [15:0]      vec_addr_o,
  input  wire logic [7:0]  vec_data_i,
  // cpu start state
  output logic [15:0]      pc_o,
  output logic [15:0]      sp_o,
  output logic             cpu_start_o,
  output logic             irq_mask_o,
  // system control
  output logic             system_reset_o,
  output logic             clk_self_mode_o,
  output logic             periph_disable_o,
  output logic             pins_hiz_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [WDOG_CNT_W-1:0] wdog_limit(input logic clks,
                                                       input logic per);
    unique case ({clks, per})
      2'b00: wdog_limit = WDOG_CNT_W'((1 << WDOG_EXP_KHZ_SHORT) - 1);
      2'b01: wdog_limit = WDOG_CNT_W'((1 << WDOG_EXP_KHZ_LONG) - 1);
      2'b10: wdog_limit = WDOG_CNT_W'((1 << WDOG_EXP_BUS_SHORT) - 1);
      2'b11: wdog_limit = WDOG_CNT_W'((1 << WDOG_EXP_BUS_LONG) - 1);
    endcase
  endfunction

  // sequence lengths in core clocks, bus runs at half the core clock
  localparam logic [6:0] DRIVE_LAST = 7'(PIN_DRIVE_BUS_CYC * BUS_DIV - 1);
  localparam logic [6:0] WAIT_LAST  = 7'(PIN_WAIT_BUS_CYC * BUS_DIV - 1);
  localparam logic [15:0] KHZ_LAST  = 16'(KHZ_DIV - 1);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchroniser

  logic pin_meta;
  logic pin_sync;

  always_ff @(posedge core_clk_i)
  begin
    pin_meta <= reset_pin_i;
    pin_sync <= pin_meta;
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus clock phase and 1 khz tick

  logic        bus_ph;
  logic [15:0] khz_cnt;
  logic        khz_tick;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      bus_ph <= 1'b0;
    else
      bus_ph <= ~bus_ph;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      khz_cnt  <= '0;
      khz_tick <= 1'b0;
    end
    else
    begin
      khz_tick <= (khz_cnt == KHZ_LAST);
      khz_cnt  <= (khz_cnt == KHZ_LAST) ? '0 : khz_cnt + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset entry

  wdr_seq_e   state;
  wdr_seq_e   next_state;
  logic [6:0] seq_cnt;
  logic       wdog_ovf;
  wdr_cause_s next_cause;
  logic       reset_req;

  always_comb
  begin
    next_cause      = '0;
    next_cause.low_voltage_detect  = lvd_reset_i;
    next_cause.ilop = illegal_opcode_i;
    next_cause.loc  = clock_loss_i;
    next_cause.wdog = wdog_ovf;
    next_cause.pin  = ~pin_sync & opt2_o.reset_pin_enable;
    reset_req = (state == SEQ_RUN) &&
                ((|next_cause) || debug_reset_i);
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_comb
  begin
    next_state = state;
    unique case (state)
      SEQ_DRIVE:
        if (seq_cnt == DRIVE_LAST)
          next_state = SEQ_WAIT;
      SEQ_WAIT:
        if (seq_cnt == WAIT_LAST)
          next_state = SEQ_SAMPLE;
      SEQ_SAMPLE:
        next_state = SEQ_VEC_HI;
      SEQ_VEC_HI:
        next_state = SEQ_VEC_LO;
      SEQ_VEC_LO:
        next_state = SEQ_VEC_END;
      SEQ_VEC_END:
        next_state = SEQ_RUN;
      SEQ_RUN:
        if (reset_req)
          next_state = SEQ_DRIVE;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
      state <= SEQ_DRIVE;
    else
      state <= next_state;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i || next_state != state)
      seq_cnt <= '0;
    else if (state == SEQ_DRIVE || state == SEQ_WAIT)
      seq_cnt <= seq_cnt + 7'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // system control outputs

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      system_reset_o   <= 1'b1;
      clk_self_mode_o  <= 1'b1;
      periph_disable_o <= 1'b1;
      pins_hiz_o       <= 1'b1;
      reset_pin_o      <= 1'b0;
      reset_pin_oe_o   <= 1'b1;
      cpu_start_o      <= 1'b0;
    end
    else
    begin
      system_reset_o   <= (next_state != SEQ_RUN);
      if (next_state == SEQ_DRIVE)
        clk_self_mode_o <= 1'b1;
      else if (next_state == SEQ_RUN)
        clk_self_mode_o <= 1'b0;
      if (next_state == SEQ_DRIVE)
      begin
        periph_disable_o <= 1'b1;
        pins_hiz_o       <= 1'b1;
      end
      else if (next_state == SEQ_RUN)
      begin
        periph_disable_o <= 1'b0;
        pins_hiz_o       <= 1'b0;
      end
      reset_pin_o    <= 1'b0;
      reset_pin_oe_o <= (next_state == SEQ_DRIVE);
      cpu_start_o    <= (next_state == SEQ_RUN) && (state != SEQ_RUN);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset cause

  wdr_cause_s cause_pend;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      cause_pend     <= '0;
      cause_pend.por <= 1'b1;
      reset_cause_o  <= '0;
    end
    else
    begin
      if (reset_req)
        cause_pend <= next_cause;
      if (state == SEQ_SAMPLE)
      begin
        reset_cause_o     <= cause_pend;
        reset_cause_o.pin <= cause_pend.pin |
                             (~pin_sync & opt2_o.reset_pin_enable);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector fetch and cpu start state

  always_ff @(posedge core_clk_i)
  begin
    vec_rd_o <= !rst_i && (next_state == SEQ_VEC_HI ||
                           next_state == SEQ_VEC_LO);
    if (rst_i || next_state == SEQ_VEC_HI)
      vec_addr_o <= RESET_VEC_HI_ADDR;
    else if (next_state == SEQ_VEC_LO)
      vec_addr_o <= RESET_VEC_LO_ADDR;
    // data answers the address shown one cycle earlier
    if (rst_i)
      pc_o <= '0;
    else if (state == SEQ_VEC_LO)
      pc_o[15:8] <= vec_data_i;
    else if (state == SEQ_VEC_END)
      pc_o[7:0] <= vec_data_i;
    if (rst_i || next_state == SEQ_DRIVE)
    begin
      sp_o       <= STACK_PTR_RESET;
      irq_mask_o <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write-once system options

  logic opt1_lock;
  logic opt2_lock;
  logic opt1_first;
  logic opt2_first;
  logic seq_rst;

  assign seq_rst    = rst_i || (state != SEQ_RUN);
  assign opt1_first = opt1_wr_i && !opt1_lock;
  assign opt2_first = opt2_wr_i && !opt2_lock;

  always_ff @(posedge core_clk_i)
  begin
    if (seq_rst)
    begin
      opt1_lock                 <= 1'b0;
      opt1_o.watchdog_enable    <= OPT1_ENABLE_RST;
      opt1_o.watchdog_period_select <= OPT1_PERIOD_RST;
    end
    else if (opt1_first)
    begin
      opt1_lock                 <= 1'b1;
      opt1_o.watchdog_enable    <= wr_data_i[OPT1_ENABLE_BIT];
      opt1_o.watchdog_period_select <= wr_data_i[OPT1_PERIOD_BIT];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (seq_rst)
    begin
      opt2_lock                    <= 1'b0;
      opt2_o.watchdog_clock_select <= OPT2_CLKSEL_RST;
      opt2_o.reset_pin_enable      <= OPT2_PINEN_RST;
    end
    else if (opt2_first)
    begin
      opt2_lock                    <= 1'b1;
      opt2_o.watchdog_clock_select <= wr_data_i[OPT2_CLKSEL_BIT];
      opt2_o.reset_pin_enable      <= wr_data_i[OPT2_PINEN_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog counter

  logic [WDOG_CNT_W-1:0] wdog_cnt;
  logic                  wdog_step;
  logic                  wdog_halt;
  logic                  wdog_clear;

  always_comb
  begin
    wdog_halt  = debug_mode_i || stop_mode_i;
    wdog_step  = opt2_o.watchdog_clock_select ? bus_ph : khz_tick;
    wdog_clear = cause_wr_i || opt1_first || opt2_first ||
                 (!opt2_o.watchdog_clock_select && wdog_halt);
  end

  always_ff @(posedge core_clk_i)
  begin
    if (seq_rst || !opt1_o.watchdog_enable)
    begin
      wdog_cnt <= '0;
      wdog_ovf <= 1'b0;
    end
    else if (wdog_clear)
    begin
      wdog_cnt <= '0;
      wdog_ovf <= 1'b0;
    end
    else if (wdog_step && !wdog_halt)
    begin
      if (wdog_cnt == wdog_limit(opt2_o.watchdog_clock_select,
                                 opt1_o.watchdog_period_select))
        wdog_ovf <= 1'b1;
      else
        wdog_cnt <= wdog_cnt + WDOG_CNT_W'(1);
    end
  end

endmodule // wdr_watchdog_reset

// *** inc/wdr_pkg.sv ***
// constants and types shared by the watchdog and reset sequencer
package wdr_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS     = 25;
  localparam int unsigned BUS_DIV           = 2;
  localparam int unsigned PIN_DRIVE_BUS_CYC = 34;
  localparam int unsigned PIN_WAIT_BUS_CYC  = 38;
  localparam int unsigned KHZ_PERIOD_NS     = 1000000;
  localparam int unsigned KHZ_DIV_CYC       = KHZ_PERIOD_NS / CLK_PERIOD_NS;

  // cpu start state
  localparam logic [15:0] RESET_VEC_HI_ADDR = 16'hfffe;
  localparam logic [15:0] RESET_VEC_LO_ADDR = 16'hffff;
  localparam logic [15:0] STACK_PTR_RESET   = 16'h00ff;

  // system_options_one field positions and reset values
  localparam int unsigned OPT1_ENABLE_BIT   = 7;
  localparam int unsigned OPT1_PERIOD_BIT   = 6;
  localparam logic        OPT1_ENABLE_RST   = 1'b1;
  localparam logic        OPT1_PERIOD_RST   = 1'b1;

  // system_options_two field positions and reset values
  localparam int unsigned OPT2_CLKSEL_BIT   = 7;
  localparam int unsigned OPT2_PINEN_BIT    = 0;
  localparam logic        OPT2_CLKSEL_RST   = 1'b0;
  localparam logic        OPT2_PINEN_RST    = 1'b1;

  // watchdog overflow exponents by {clock_select, period_select}
  localparam int unsigned WDOG_CNT_W        = 18;
  localparam int unsigned WDOG_EXP_KHZ_SHORT = 5;
  localparam int unsigned WDOG_EXP_KHZ_LONG  = 8;
  localparam int unsigned WDOG_EXP_BUS_SHORT = 13;
  localparam int unsigned WDOG_EXP_BUS_LONG  = 18;

  typedef struct packed {
    logic por;
    logic pin;
    logic wdog;
    logic ilop;
    logic low_voltage_detect;
    logic loc;
  } wdr_cause_s;

  typedef struct packed {
    logic watchdog_enable;
    logic watchdog_period_select;
  } wdr_opt1_s;

  typedef struct packed {
    logic watchdog_clock_select;
    logic reset_pin_enable;
  } wdr_opt2_s;

  typedef enum logic [2:0] {
    SEQ_DRIVE,
    SEQ_WAIT,
    SEQ_SAMPLE,
    SEQ_VEC_HI,
    SEQ_VEC_LO,
    SEQ_VEC_END,
    SEQ_RUN
  } wdr_seq_e;

endpackage

// *** verif/wdr_far_model.sv ***
// far side model: reset pin with pull-up and reset vector memory
`timescale 1ns/100ps
module wdr_far_model
  import wdr_pkg::*;
#(
  parameter logic [15:0] VECTOR = 16'h5a3c
)(
  // clock
  input  wire logic        core_clk_i,
  // reset pin
  input  wire logic        pin_drive_i,
  input  wire logic        pin_oe_i,
  input  wire logic        hold_low_i,
  output logic             pin_o,
  // vector memory
  input  wire logic [15:0] addr_i,
  output logic [7:0]       data_o
);
  // released pin is pulled up unless held low from outside
  assign pin_o = !((pin_oe_i && !pin_drive_i) || hold_low_i);
  initial data_o = 8'h00;
  // byte of the previous address, changing junk elsewhere
  always @(posedge core_clk_i)
  begin
    if (addr_i == RESET_VEC_HI_ADDR)
      data_o <= VECTOR[15:8];
    else if (addr_i == RESET_VEC_LO_ADDR)
      data_o <= VECTOR[7:0];
    else
      data_o <= ~data_o;
  end
endmodule // wdr_far_model

// *** verif/wdr_watchdog_reset_monitor.sv ***
// assertion checker for the watchdog and reset sequencer
`timescale 1ns/100ps
module wdr_watchdog_reset_monitor
  import wdr_pkg::*;
(
  // clock and reset
  input wire logic        core_clk_i,
  input wire logic        rst_i,
  // pin and writes
  input wire logic        reset_pin_o,
  input wire logic        reset_pin_oe_o,
  input wire logic        cause_wr_i,
  input wire logic        opt1_wr_i,
  input wire logic        opt2_wr_i,
  input wire logic [7:0]  wr_data_i,
  // state
  input wire wdr_cause_s  reset_cause_o,
  input wire wdr_opt1_s   opt1_o,
  input wire wdr_opt2_s   opt2_o,
  input wire logic        vec_rd_o,
  input wire logic [15:0] vec_addr_o,
  input wire logic [15:0] sp_o,
  input wire logic        cpu_start_o,
  input wire logic        irq_mask_o,
  input wire logic        system_reset_o,
  input wire logic        clk_self_mode_o,
  input wire logic        periph_disable_o,
  input wire logic        pins_hiz_o
);
  logic [7:0] oe_cnt;
  logic [7:0] wd_q;
  logic       live;
  logic       o1_done;
  logic       o2_done;
  ////////////////////////////////////////////////////////////////////////
  // pin drive length, live once the pin was seen released
  always_ff @(posedge core_clk_i)
  begin
    oe_cnt <= (rst_i || !reset_pin_oe_o) ? 8'h00 : oe_cnt + 8'h01;
    live   <= rst_i ? 1'b0 : (live || !reset_pin_oe_o);
  end
  // option write tracking
  always_ff @(posedge core_clk_i)
  begin
    wd_q    <= wr_data_i;
    o1_done <= (rst_i || system_reset_o) ? 1'b0 : (o1_done || opt1_wr_i);
    o2_done <= (rst_i || system_reset_o) ? 1'b0 : (o2_done || opt2_wr_i);
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_fetch;
    vec_rd_o && vec_addr_o == 16'hfffe ##1
    vec_rd_o && vec_addr_o == 16'hffff ##1 !vec_rd_o;
  endsequence
  sequence s_start;
    cpu_start_o && !system_reset_o;
  endsequence
  chk_vec_order: assert property (
    $rose(vec_rd_o) |-> s_fetch ##1 s_start)
    else $error("vector fetch order wrong");
  chk_pin_low_time: assert property (
    $fell(reset_pin_oe_o) && live |-> oe_cnt == 8'h44)
    else $error("reset pin drive length wrong");
  chk_pin_drive_zero: assert property (
    reset_pin_oe_o |-> !reset_pin_o)
    else $error("reset pin driven high");
  chk_sample_wait: assert property (
    $fell(reset_pin_oe_o) |-> ##77 $rose(vec_rd_o))
    else $error("pin sample wait wrong");
  chk_start_state: assert property (
    cpu_start_o |-> sp_o == 16'h00ff && irq_mask_o)
    else $error("start state wrong");
  chk_reset_outputs: assert property (
    system_reset_o |-> clk_self_mode_o && periph_disable_o && pins_hiz_o)
    else $error("reset outputs not held");
  chk_opt_defaults: assert property (
    $fell(system_reset_o) |-> opt1_o == 2'b11 && opt2_o == 2'b01)
    else $error("option defaults wrong");
  chk_opt1_write: assert property (
    opt1_wr_i && !system_reset_o && !o1_done
    |=> opt1_o == {wd_q[7], wd_q[6]} || system_reset_o)
    else $error("first option write not taken");
  chk_opt_lock: assert property (
    o1_done && o2_done && !system_reset_o
    |=> ($stable(opt1_o) && $stable(opt2_o)) || system_reset_o)
    else $error("locked options changed");
  chk_cause_kept: assert property (
    cause_wr_i && !system_reset_o |=> $stable(reset_cause_o) || system_reset_o)
    else $error("service write changed cause");
endmodule // wdr_watchdog_reset_monitor

bind wdr_watchdog_reset wdr_watchdog_reset_monitor i_wdr_watchdog_reset_monitor (
  .core_clk_i, .rst_i, .reset_pin_o, .reset_pin_oe_o, .cause_wr_i,
  .opt1_wr_i, .opt2_wr_i, .wr_data_i, .reset_cause_o, .opt1_o, .opt2_o,
  .vec_rd_o, .vec_addr_o, .sp_o, .cpu_start_o, .irq_mask_o,
  .system_reset_o, .clk_self_mode_o, .periph_disable_o, .pins_hiz_o
);

// *** verif/wdr_watchdog_reset_tb_top.sv ***
// self-checking bench for the watchdog and reset sequencer
`timescale 1ns/100ps
module wdr_watchdog_reset_tb_top import wdr_pkg::*;;
  localparam int unsigned DIV   = 8;
  localparam logic [15:0] VEC   = 16'h5a3c;
  localparam int          LIMIT = 80000;
  typedef struct packed {
    logic [3:0]  src;
    logic [1:0]  mode;
    logic [15:0] lo;
    logic [15:0] hi;
    logic [5:0]  cause;
  } wdr_row_s;
  // src {lvd, opcode, debug, clock loss}; mode {clock_select, period}
  localparam wdr_row_s ROWS [8] = '{
    '{4'h8, 2'b00, 16'h0000, 16'h0004, 6'h02},
    '{4'h4, 2'b00, 16'h0000, 16'h0004, 6'h04},
    '{4'h2, 2'b00, 16'h0000, 16'h0004, 6'h00},
    '{4'h1, 2'b00, 16'h0000, 16'h0004, 6'h01},
    '{4'h0, 2'b00, 16'h00f4, 16'h010c, 6'h08},
    '{4'h0, 2'b01, 16'h07f4, 16'h080c, 6'h08},
    '{4'h0, 2'b10, 16'h3ff8, 16'h4008, 6'h08},
    '{4'h0, 2'b11, 16'h4e20, 16'h4e20, 6'h3f}};
  logic core_clk_i = 1'b0, rst_i = 1'b1, hold_low = 1'b0;
  logic lvd_reset_i = 1'b0, illegal_opcode_i = 1'b0;
  logic debug_reset_i = 1'b0, clock_loss_i = 1'b0;
  logic debug_mode_i = 1'b0, stop_mode_i = 1'b0;
  logic cause_wr_i = 1'b0, opt1_wr_i = 1'b0, opt2_wr_i = 1'b0;
  logic [7:0]  wr_data_i = 8'h00;
  logic [7:0]  vec_data_i;
  logic [15:0] vec_addr_o, pc_o, sp_o;
  logic        reset_pin_i, reset_pin_o, reset_pin_oe_o, vec_rd_o;
  logic        cpu_start_o, irq_mask_o, system_reset_o;
  logic        clk_self_mode_o, periph_disable_o, pins_hiz_o;
  wdr_cause_s  reset_cause_o;
  wdr_opt1_s   opt1_o;
  wdr_opt2_s   opt2_o;
  int          n_mismatch = 0, num_checks = 0, cyc = 0;
  ////////////////////////////////////////////////////////////////////////
  wdr_watchdog_reset #(.KHZ_DIV(DIV)) i_wdr_watchdog_reset (
    .core_clk_i, .rst_i, .lvd_reset_i, .illegal_opcode_i, .debug_reset_i,
    .clock_loss_i, .reset_pin_i, .reset_pin_o, .reset_pin_oe_o,
    .debug_mode_i, .stop_mode_i, .cause_wr_i, .opt1_wr_i, .opt2_wr_i,
    .wr_data_i, .reset_cause_o, .opt1_o, .opt2_o, .vec_rd_o, .vec_addr_o,
    .vec_data_i, .pc_o, .sp_o, .cpu_start_o, .irq_mask_o, .system_reset_o,
    .clk_self_mode_o, .periph_disable_o, .pins_hiz_o);
  wdr_far_model #(.VECTOR(VEC)) i_wdr_far_model (
    .core_clk_i, .pin_drive_i(reset_pin_o), .pin_oe_i(reset_pin_oe_o),
    .hold_low_i(hold_low), .pin_o(reset_pin_i), .addr_i(vec_addr_o),
    .data_o(vec_data_i));
  ////////////////////////////////////////////////////////////////////////
  always #12.5 core_clk_i = ~core_clk_i;
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge core_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == LIMIT)
    begin
      n_mismatch++;
      $display("Error at %0t: run too long", $time);
      close_out;
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic wr(input int sel, input logic [7:0] d);
    wr_data_i = d;
    {cause_wr_i, opt1_wr_i, opt2_wr_i} = {sel == 0, sel == 1, sel == 2};
    tick(1);
    {cause_wr_i, opt1_wr_i, opt2_wr_i} = 3'b000;
    tick(1);
  endtask
  task automatic setup(input logic [7:0] d1, input logic [7:0] d2);
    wr(1, d1);
    wr(2, d2);
  endtask
  task automatic wait_start;
    int i;
    i = 0;
    while (cpu_start_o !== 1'b1 && i < 400)
    begin
      tick(1);
      i++;
    end
    chk(i < 400, 1'b1);
    tick(1);
  endtask
  task automatic boot;
    rst_i = 1'b1;
    tick(20);
    rst_i = 1'b0;
    wait_start;
  endtask
  task automatic window(input int lo, input int hi, input logic exp);
    int n;
    n = 0;
    while (system_reset_o !== 1'b1 && n < hi)
    begin
      tick(1);
      n++;
    end
    chk({n >= lo, system_reset_o}, {1'b1, exp});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    boot;
    for (int r = 0; r < 8; r++)
    begin
      setup({1'b1, ROWS[r].mode[0], 6'h00}, {ROWS[r].mode[1], 7'h01});
      {lvd_reset_i, illegal_opcode_i, debug_reset_i, clock_loss_i} =
        ROWS[r].src;
      tick(1);
      {lvd_reset_i, illegal_opcode_i, debug_reset_i, clock_loss_i} = 4'h0;
      window(ROWS[r].lo, ROWS[r].hi, ROWS[r].cause != 6'h3f);
      if (ROWS[r].cause != 6'h3f)
      begin
        wait_start;
        chk(reset_cause_o, ROWS[r].cause);
      end
      $display("test row %0d done", r);
    end
    boot;
    chk(pc_o, VEC);
    chk(sp_o, 16'h00ff);
    chk(irq_mask_o, 1'b1);
    chk(reset_cause_o, 6'h20);
    chk({opt1_o, opt2_o}, 4'hd);
    chk({clk_self_mode_o, periph_disable_o, pins_hiz_o}, 3'h0);
    $display("test power on done");
    setup(8'h00, 8'h01);
    wr(1, 8'hc0);
    chk(opt1_o, 2'b00);
    window(3000, 3000, 1'b0);
    $display("test lock and disable done");
    boot;
    setup(8'h80, 8'h01);
    repeat (10)
    begin
      tick(150);
      wr(0, 8'h5a);
    end
    chk({system_reset_o, reset_cause_o}, 7'h20);
    window(244, 268, 1'b1);
    wait_start;
    chk(reset_cause_o, 6'h08);
    $display("test service done");
    setup(8'h80, 8'h01);
    tick(200);
    debug_mode_i = 1'b1;
    tick(400);
    debug_mode_i = 1'b0;
    window(244, 268, 1'b1);
    wait_start;
    $display("test debug clear done");
    setup(8'h80, 8'h81);
    tick(8000);
    stop_mode_i = 1'b1;
    tick(1000);
    stop_mode_i = 1'b0;
    window(8370, 8398, 1'b1);
    wait_start;
    $display("test stop hold done");
    setup(8'h00, 8'h00);
    hold_low = 1'b1;
    window(100, 100, 1'b0);
    hold_low = 1'b0;
    boot;
    hold_low = 1'b1;
    window(0, 8, 1'b1);
    for (int i = 0; i < 200 && reset_pin_oe_o !== 1'b0; i++)
      tick(1);
    tick(76);
    hold_low = 1'b0;
    wait_start;
    chk(reset_cause_o, 6'h10);
    $display("test pin reset done");
    lvd_reset_i = 1'b1;
    tick(1);
    lvd_reset_i = 1'b0;
    for (int i = 0; i < 200 && reset_pin_oe_o !== 1'b0; i++)
      tick(1);
    tick(40);
    hold_low = 1'b1;
    tick(36);
    hold_low = 1'b0;
    wait_start;
    chk(reset_cause_o, 6'h12);
    $display("test pin sample done");
    close_out;
  end
endmodule // wdr_watchdog_reset_tb_top
